// file: charge_time_unit_consts.svh
`ifndef CHARGE_TIME_UNIT_CONSTS_SVH
`define CHARGE_TIME_UNIT_CONSTS_SVH

`define CTRL1_OFFSET       12'h000
`define CTRL1_RESET        16'h0000
`define CTRL1_WMASK        16'hbf00
`define BIT_UNIT_ENABLE    15
`define BIT_IDLE_STOP      13
`define BIT_TIME_GEN       12
`define BIT_HW_EDGE        11
`define BIT_EDGE_ORDER     10
`define BIT_SRC_GROUND     9
`define BIT_CONV_TRIGGER   8
`define STATUS_OFFSET      12'h004
`define EDGE_CTRL_OFFSET   12'h008
`define BIT_EDGE1          0
`define BIT_EDGE2          1

`endif

// file: charge_time_unit_pkg.sv
package charge_time_unit_pkg;
  typedef logic [15:0] reg16_t;
  typedef enum logic [1:0] {
    edge_wait_1,
    edge_wait_2,
    edge_done
  } edge_state_e;
endpackage

// file: edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
module edge_sync #(
  parameter int width = 4
) (
  input  wire logic             core_clk,  // clock
  input  wire logic             nrst,      // async reset, low
  input  wire logic [width-1:0] async_in,  // pins from outside
  output logic      [width-1:0] sync_out   // synchronised levels
);
  logic [width-1:0] stage1;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// file: charge_time_unit_control.sv
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "charge_time_unit_consts.svh"

module charge_time_unit_control (
  input  wire logic        core_clk,        // 10 MHz clock
  input  wire logic        nrst,            // async reset, low
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb enable
  input  wire logic        pwrite,          // apb direction
  input  wire logic [11:0] paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  output logic      [31:0] prdata,          // apb read data
  output logic             pready,          // apb ready
  output logic             pslverr,         // apb error
  input  wire logic        device_idle,     // device in idle mode
  input  wire logic        timer_source,    // hardware edge 1 source
  input  wire logic        external_edge_pin, // hardware edge 2 pin
  output logic             unit_active,     // unit running
  output logic             time_generation_enable, // delay generator on
  output logic             current_source_ground,  // ground source output
  output logic             converter_trigger,      // converter start pulse
  output logic             edge1_seen,      // edge 1 status
  output logic             edge2_seen       // edge 2 status
);
  charge_time_unit_pkg::reg16_t      ctrl;
  charge_time_unit_pkg::reg16_t      next_ctrl;
  logic [1:0]                        edge_stat;
  logic [1:0]                        next_edge_stat;
  logic [31:0]                       next_prdata;
  logic                              next_pready;
  logic                              next_pslverr;
  logic                              next_active;
  logic                              next_trig;
  logic                              next_time_generation_enable;
  logic [1:0]                        hw_sync;
  logic [1:0]                        hw_prev;
  logic [1:0]                        hw_rise;
  charge_time_unit_pkg::edge_state_e edge_st;
  charge_time_unit_pkg::edge_state_e next_edge_st;
  logic                              setup;
  logic                              mapped;

  edge_sync #(.width(2)) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in ({external_edge_pin, timer_source}),
    .sync_out (hw_sync)
  );

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  assign setup   = psel && !penable;
  assign hw_rise = hw_sync & ~hw_prev;
  assign mapped  = addr_is(paddr, `CTRL1_OFFSET) || addr_is(paddr, `STATUS_OFFSET)
                   || addr_is(paddr, `EDGE_CTRL_OFFSET);

  always_comb
  begin
    logic run;
    logic e1;
    logic e2;
    run            = 1'b0;
    e1             = 1'b0;
    e2             = 1'b0;
    next_ctrl      = ctrl;
    next_edge_stat = edge_stat;
    next_edge_st   = edge_st;
    next_prdata    = prdata;
    next_pready    = 1'b0;
    next_pslverr   = 1'b0;
    next_trig      = 1'b0;
    // answer in the access cycle after setup
    if (setup)
    begin
      next_pready  = 1'b1;
      next_pslverr = !mapped;
      next_prdata  = 32'h0000_0000;
      if (!pwrite)
      begin
        if (addr_is(paddr, `CTRL1_OFFSET))
          next_prdata = {16'h0000, ctrl};
        else if (addr_is(paddr, `STATUS_OFFSET))
          next_prdata = {29'h0, unit_active, edge_stat};
      end
    end
    if (psel && penable && pready && pwrite && addr_is(paddr, `CTRL1_OFFSET))
      next_ctrl = pwdata[15:0] & `CTRL1_WMASK;
    next_time_generation_enable = next_ctrl[`BIT_TIME_GEN] && next_ctrl[`BIT_UNIT_ENABLE];
    run = ctrl[`BIT_UNIT_ENABLE] && !(ctrl[`BIT_IDLE_STOP] && device_idle);
    next_active = run;
    if (ctrl[`BIT_HW_EDGE])
    begin
      e1 = hw_rise[0];
      e2 = hw_rise[1];
    end
    else if (psel && penable && pready && pwrite && addr_is(paddr, `EDGE_CTRL_OFFSET))
    begin
      e1 = pwdata[`BIT_EDGE1];
      e2 = pwdata[`BIT_EDGE2];
    end
    if (!run)
    begin
      e1 = 1'b0;
      e2 = 1'b0;
    end
    if (ctrl[`BIT_EDGE_ORDER] && !edge_stat[`BIT_EDGE1] && !e1)
      e2 = 1'b0;
    next_edge_stat = edge_stat | {e2, e1};
    if (psel && penable && pready && pwrite && addr_is(paddr, `STATUS_OFFSET))
      next_edge_stat = (edge_stat & pwdata[1:0]) | {e2, e1};
    if (!ctrl[`BIT_UNIT_ENABLE])
      next_edge_stat = 2'b00;
    unique case (edge_st)
      charge_time_unit_pkg::edge_wait_1:
        if (next_edge_stat[`BIT_EDGE1])
          next_edge_st = charge_time_unit_pkg::edge_wait_2;
      charge_time_unit_pkg::edge_wait_2:
        if (!next_edge_stat[`BIT_EDGE1])
          next_edge_st = charge_time_unit_pkg::edge_wait_1;
        else if (next_edge_stat[`BIT_EDGE2])
        begin
          next_edge_st = charge_time_unit_pkg::edge_done;
          next_trig    = run && ctrl[`BIT_CONV_TRIGGER];
        end
      charge_time_unit_pkg::edge_done:
        if (!next_edge_stat[`BIT_EDGE2])
          next_edge_st = charge_time_unit_pkg::edge_wait_1;
      default:
        next_edge_st = charge_time_unit_pkg::edge_wait_1;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl                   <= `CTRL1_RESET;
      edge_stat              <= 2'b00;
      edge_st                <= charge_time_unit_pkg::edge_wait_1;
      prdata                 <= 32'h0000_0000;
      pready                 <= 1'b0;
      pslverr                <= 1'b0;
      hw_prev                <= 2'b00;
      unit_active            <= 1'b0;
      time_generation_enable <= 1'b0;
      current_source_ground  <= 1'b0;
      converter_trigger      <= 1'b0;
      edge1_seen             <= 1'b0;
      edge2_seen             <= 1'b0;
    end
    else
    begin
      ctrl                   <= next_ctrl;
      edge_stat              <= next_edge_stat;
      edge_st                <= next_edge_st;
      prdata                 <= next_prdata;
      pready                 <= next_pready;
      pslverr                <= next_pslverr;
      hw_prev                <= hw_sync;
      unit_active            <= next_active;
      time_generation_enable <= next_time_generation_enable;
      current_source_ground  <= next_ctrl[`BIT_SRC_GROUND];
      converter_trigger      <= next_trig;
      edge1_seen             <= next_edge_stat[`BIT_EDGE1];
      edge2_seen             <= next_edge_stat[`BIT_EDGE2];
    end
  end

  ctrl_reserved_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (ctrl & ~`CTRL1_WMASK) == 16'h0000) else $error("reserved bits set");
  read_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (setup && !pwrite && addr_is(paddr, `CTRL1_OFFSET)) |=> prdata[31:16] == 16'h0
    && prdata[14] == 1'b0 && prdata[7:0] == 8'h00) else $error("reserved read nonzero");
  disabled_idle_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !ctrl[`BIT_UNIT_ENABLE] |=> !unit_active) else $error("active while disabled");
  idle_stop_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (ctrl[`BIT_IDLE_STOP] && device_idle) |=> !unit_active) else $error("ran in idle");
  idle_run_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (ctrl[`BIT_UNIT_ENABLE] && !ctrl[`BIT_IDLE_STOP]) |=> unit_active)
    else $error("stopped while enabled");
  time_gen_a: assert property (@(posedge core_clk) disable iff (!nrst)
    time_generation_enable == (ctrl[`BIT_TIME_GEN] && ctrl[`BIT_UNIT_ENABLE]))
    else $error("time generation mismatch");
  ground_follow_a: assert property (@(posedge core_clk) disable iff (!nrst)
    current_source_ground == ctrl[`BIT_SRC_GROUND]) else $error("ground mismatch");
  trigger_gate_a: assert property (@(posedge core_clk) disable iff (!nrst)
    converter_trigger |-> $past(ctrl[`BIT_CONV_TRIGGER])) else $error("stray trigger");
  edge_order_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ($past(ctrl[`BIT_EDGE_ORDER]) && $rose(edge_stat[1])) |-> edge_stat[0])
    else $error("edge 2 before edge 1");
  hw_ignore_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (ctrl[`BIT_HW_EDGE] && hw_rise == 2'b00) |=> !$rose(edge_stat[0]))
    else $error("edge without hardware source");
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "charge_time_unit_consts.svh"
module tb_top;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        device_idle = 1'b0;
  logic        timer_source = 1'b0;
  logic        external_edge_pin = 1'b0;
  logic        unit_active;
  logic        time_generation_enable;
  logic        current_source_ground;
  logic        converter_trigger;
  logic        edge1_seen;
  logic        edge2_seen;
  logic [31:0] rdata;
  logic        rerr;
  int          num_errors = 0;
  int          checks_done = 0;
  int          trig_cnt = 0;

  charge_time_unit_control dut (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .device_idle, .timer_source, .external_edge_pin, .unit_active,
    .time_generation_enable, .current_source_ground, .converter_trigger, .edge1_seen,
    .edge2_seen);

  always #50 core_clk = ~core_clk;

  // counts converter start pulses
  always @(posedge core_clk)
    if (converter_trigger === 1'b1)
      trig_cnt++;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge core_clk);
    end
    chk("pready", 32'h1, {31'h0, pready});
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic settle();
    repeat (6) @(posedge core_clk);
  endtask

  task automatic t_regs();
    apb(`CTRL1_OFFSET, 1'b0, 32'h0);
    chk("ctrl reset", 32'h0, rdata);
    chk("outs reset", 32'h0, {unit_active, time_generation_enable, current_source_ground});
    apb(`CTRL1_OFFSET, 1'b1, 32'hffffffff);
    apb(`CTRL1_OFFSET, 1'b0, 32'h0);
    chk("ctrl mask", 32'h0000bf00, rdata);
    settle();
    chk("outs on", 32'h7, {unit_active, time_generation_enable, current_source_ground});
    device_idle <= 1'b1;
    settle();
    chk("idle stop", 32'h0, {31'h0, unit_active});
    apb(`CTRL1_OFFSET, 1'b1, 32'h00009f00);
    settle();
    chk("idle run", 32'h1, {31'h0, unit_active});
    device_idle <= 1'b0;
    apb(`CTRL1_OFFSET, 1'b1, 32'h00001200);
    settle();
    chk("outs off", 32'h1, {unit_active, time_generation_enable, current_source_ground});
    apb(12'h00c, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    $display("test regs done");
  endtask

  task automatic t_soft();
    apb(`CTRL1_OFFSET, 1'b1, 32'h00008200);
    chk("discharge on", 32'h1, {31'h0, current_source_ground});
    apb(`CTRL1_OFFSET, 1'b1, 32'h00008500);
    chk("time_generation_enable gnd off", 32'h0, {time_generation_enable, current_source_ground});
    apb(`EDGE_CTRL_OFFSET, 1'b1, 32'h2);
    settle();
    chk("edge2 early", 32'h0, {31'h0, edge2_seen});
    apb(`EDGE_CTRL_OFFSET, 1'b1, 32'h1);
    apb(`EDGE_CTRL_OFFSET, 1'b1, 32'h2);
    settle();
    chk("edges", 32'h3, {edge2_seen, edge1_seen});
    chk("trig soft", 32'h1, trig_cnt);
    apb(`STATUS_OFFSET, 1'b0, 32'h0);
    chk("status", 32'h7, rdata);
    apb(`CTRL1_OFFSET, 1'b1, 32'h00008400);
    apb(`STATUS_OFFSET, 1'b1, 32'h0);
    apb(`EDGE_CTRL_OFFSET, 1'b1, 32'h1);
    apb(`EDGE_CTRL_OFFSET, 1'b1, 32'h2);
    settle();
    chk("no trig", 32'h1, trig_cnt);
    apb(`CTRL1_OFFSET, 1'b1, 32'h00008000);
    apb(`STATUS_OFFSET, 1'b1, 32'h0);
    apb(`EDGE_CTRL_OFFSET, 1'b1, 32'h2);
    settle();
    chk("edge2 free", 32'h2, {edge2_seen, edge1_seen});
    $display("test soft done");
  endtask

  task automatic t_hw();
    apb(`CTRL1_OFFSET, 1'b1, 32'h00008900);
    apb(`STATUS_OFFSET, 1'b1, 32'h0);
    apb(`EDGE_CTRL_OFFSET, 1'b1, 32'h3);
    settle();
    chk("sw ignored", 32'h0, {edge2_seen, edge1_seen});
    timer_source <= 1'b1;
    settle();
    chk("hw edge1", 32'h1, {edge2_seen, edge1_seen});
    external_edge_pin <= 1'b1;
    settle();
    chk("hw edge2", 32'h3, {edge2_seen, edge1_seen});
    chk("trig hw", 32'h2, trig_cnt);
    $display("test hw done");
  endtask

  task automatic t_reset();
    apb(`CTRL1_OFFSET, 1'b1, 32'h0000bf00);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    chk("outs rst", 32'h0, {unit_active, time_generation_enable, current_source_ground,
      edge2_seen, edge1_seen});
    apb(`CTRL1_OFFSET, 1'b0, 32'h0);
    chk("ctrl rst", 32'h0, rdata);
    $display("test reset done");
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #200000;
    num_errors++;
    finish_test();
  end

  initial
  begin
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_soft();
    t_hw();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire
